// file: verilog/mbacs_regs.sv
`timescale 1ns/100ps
// Summary of operation
// - Pending diagnostic sets slot bit when enabled
// - Pending process alarm always sets slot bit
// - Reading diagnostic memory confirms and clears bit
// - Extra diagnostics wait until current one confirmed
// - Reading alarm memory confirms and clears bit
// - Alarm mode one: extra alarms wait until current one confirmed
// - Two-bit status per module, 128-bit field
// - Remaining time in 10 ms; 0 expired, FFFF off
// - Preset times 10 ms; zero disables watchdog
// - Exchange only when off or running; reload applies
// - Reload bit 0 loads counter from preset
// - Bit 8 reactivates an expired watchdog
// - LOCK code pair locks web force mode
// - FREE code pair unlocks force mode
// - Late mode: first write requests authorization
// - Early mode: authorization requested at connect
// - Single-writer: one holder until it disconnects
// - After holder leaves, next writer or (early mode) next connect gets authorization
// - Idle connections dropped after timeout seconds
// - Reference check off: exchange starts unchecked
// - Reference check on: lists must match first
// - Alarm mode one needs confirmation by read
// - Diagnostic mode one enables confirmable diagnostics
module mbacs_regs
  import mbacs_pkg::*;
#(
  parameter int          NCONN       = 4,
  parameter int          WAITW       = 2,
  parameter int          WD_TICK_CYC = WD_UNIT_CYC,
  parameter int          SEC_CYC     = IDLE_UNIT_CYC,
  parameter logic [15:0] MAP_REV_ID  = 16'h0001  // Arbitrary value
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // Register request from the Modbus side
  input  wire logic                      req_valid,
  input  wire logic                      req_write,
  input  wire logic [$clog2(NCONN)-1:0]  req_conn,
  input  wire logic [15:0]               req_addr,
  input  wire logic [15:0]               req_wdata,
  // Register answer
  output logic                           resp_valid_r,
  output logic [15:0]                    resp_rdata_r,
  output logic [7:0]                     resp_exc_r,
  // Connection events
  input  wire logic                      conn_open,
  input  wire logic [$clog2(NCONN)-1:0]  conn_open_id,
  input  wire logic                      conn_close,
  input  wire logic [$clog2(NCONN)-1:0]  conn_close_id,
  output logic [NCONN-1:0]               conn_drop_r,
  // Module events and state
  input  wire logic                      diag_evt,
  input  wire logic [5:0]                diag_slot,
  input  wire logic                      alarm_evt,
  input  wire logic [5:0]                alarm_slot,
  input  wire logic [127:0]              mod_status,
  input  wire logic [15:0]               out_img_bits,
  input  wire logic [15:0]               in_img_bits,
  input  wire logic                      ref_list_match,
  // Block outputs
  output logic                           exch_enable_r,
  output logic                           force_locked_r,
  output logic [63:0]                    diag_flags_r,
  output logic [63:0]                    alarm_flags_r
);

  localparam int CW = $clog2(NCONN);

  // Connection indexes must cover exactly NCONN so drop and owner lookups stay in range
  if (NCONN < 2 || (1 << CW) != NCONN || WAITW < 1 || WD_TICK_CYC < 1 || SEC_CYC < 1)
  begin : g_param_check
    $error("mbacs_regs: unsupported parameter value");
  end

  // Configuration registers
  logic [15:0]       conn_mode_r;
  logic [15:0]       wd_preset_r;
  logic [15:0]       idle_timeout_r;
  logic [15:0]       ref_check_r;
  logic [15:0]       alarm_mode_r;
  logic [15:0]       diag_mode_r;
  logic [127:0]      mod_status_r;

  // Decode
  logic              wr;
  logic              rd;
  logic [5:0]        req_slot;
  logic              rd_diag_mem;
  logic              rd_alarm_mem;
  logic              single_writer_mode;
  logic              early_write_grant;
  logic              owner_v_r;
  logic [CW-1:0]     owner_r;
  logic              write_allowed;

  assign wr                 = req_valid && req_write;
  assign rd                 = req_valid && !req_write;
  assign req_slot           = req_addr[SLOT_LSB+5:SLOT_LSB];
  assign rd_diag_mem        = rd && req_addr[15:12] == AREA_DIAG_MEM
                              && req_addr[11] == 1'b0;
  assign rd_alarm_mem       = rd && req_addr[15:12] == AREA_ALARM_MEM
                              && req_addr[11] == 1'b0;
  assign single_writer_mode = conn_mode_r[MODE_SINGLE_BIT];
  assign early_write_grant  = conn_mode_r[MODE_EARLY_BIT];
  // Holder owns; otherwise a free slot is taken by this write
  assign write_allowed      = !single_writer_mode || !owner_v_r || owner_r == req_conn;

  // Decode of writable addresses, used both for storing and for the answer
  logic              wr_known;
  always_comb begin
    unique case (req_addr)
      ADDR_CONN_MODE, ADDR_WD_PRESET, ADDR_WD_RELOAD, ADDR_FORCE_LOCK,
      ADDR_FORCE_LOCK_HI, ADDR_IDLE_TIMEOUT, ADDR_REF_CHECK,
      ADDR_ALARM_MODE, ADDR_DIAG_MODE: wr_known = 1'b1;
      default:                         wr_known = 1'b0;
    endcase
  end

  logic              wr_ok;
  assign wr_ok = wr && wr_known && write_allowed;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      conn_mode_r    <= CFG_RESET;
      wd_preset_r    <= CFG_RESET;
      idle_timeout_r <= CFG_RESET;
      ref_check_r    <= CFG_RESET;
      alarm_mode_r   <= CFG_RESET;
      diag_mode_r    <= CFG_RESET;
    end else if (wr_ok) begin
      unique case (req_addr)
        ADDR_CONN_MODE:    conn_mode_r    <= {14'h0000, req_wdata[1:0]};
        ADDR_WD_PRESET:    wd_preset_r    <= req_wdata;
        ADDR_IDLE_TIMEOUT: idle_timeout_r <= req_wdata;
        ADDR_REF_CHECK:    ref_check_r    <= req_wdata;
        ADDR_ALARM_MODE:   alarm_mode_r   <= req_wdata;
        ADDR_DIAG_MODE:    diag_mode_r    <= req_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mod_status_r <= 128'h0;
    end else begin
      mod_status_r <= mod_status;
    end
  end

  // Per-module pending item plus a saturating count of queued ones.
  // Only a count is kept: message contents live in the memory areas.
  logic [63:0]       diag_pend_r;
  logic [63:0]       alarm_pend_r;
  logic [WAITW-1:0]  diag_wait_r  [64];
  logic [WAITW-1:0]  alarm_wait_r [64];
  logic              diag_on;
  logic              alarm_confirm;

  assign diag_on       = diag_mode_r == 16'h0001;
  assign alarm_confirm = alarm_mode_r == 16'h0001;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      diag_pend_r <= 64'h0;
      for (int i = 0; i < 64; i++) begin
        diag_wait_r[i] <= '0;
      end
    end else if (!diag_on) begin
      // Deactivated diagnostics need no confirmation and are not collected
      diag_pend_r <= 64'h0;
      for (int i = 0; i < 64; i++) begin
        diag_wait_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 64; i++) begin
        if (rd_diag_mem && req_slot == i[5:0] && diag_pend_r[i]) begin
          // Confirm: next queued one becomes current; a same-cycle event wins
          if (diag_evt && diag_slot == i[5:0]) begin
            diag_pend_r[i] <= 1'b1;
          end else if (diag_wait_r[i] != '0) begin
            diag_wait_r[i] <= diag_wait_r[i] - 1'b1;
          end else begin
            diag_pend_r[i] <= 1'b0;
          end
        end else if (diag_evt && diag_slot == i[5:0]) begin
          if (!diag_pend_r[i]) begin
            diag_pend_r[i] <= 1'b1;
          end else if (diag_wait_r[i] != '1) begin
            diag_wait_r[i] <= diag_wait_r[i] + 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      alarm_pend_r <= 64'h0;
      for (int i = 0; i < 64; i++) begin
        alarm_wait_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 64; i++) begin
        if (rd_alarm_mem && req_slot == i[5:0] && alarm_pend_r[i]) begin
          if (alarm_evt && alarm_slot == i[5:0]) begin
            alarm_pend_r[i] <= 1'b1;
          end else if (alarm_confirm && alarm_wait_r[i] != '0) begin
            alarm_wait_r[i] <= alarm_wait_r[i] - 1'b1;
          end else begin
            alarm_pend_r[i] <= 1'b0;
          end
        end else if (alarm_evt && alarm_slot == i[5:0]) begin
          if (!alarm_pend_r[i]) begin
            alarm_pend_r[i] <= 1'b1;
          end else if (alarm_confirm && alarm_wait_r[i] != '1) begin
            alarm_wait_r[i] <= alarm_wait_r[i] + 1'b1;
          end
        end
        // Without confirmation mode the latest alarm just replaces the shown one
        if (!alarm_confirm) begin
          alarm_wait_r[i] <= '0;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      diag_flags_r  <= 64'h0;
      alarm_flags_r <= 64'h0;
    end else begin
      diag_flags_r  <= diag_on ? diag_pend_r : 64'h0;
      alarm_flags_r <= alarm_pend_r;
    end
  end

  // Watchdog over process data exchange
  logic              wd_active_r;
  logic [15:0]       wd_cur_r;
  logic [15:0]       wd_load_r;
  logic [31:0]       wd_tick_cnt_r;
  logic              wd_tick;
  logic              wd_reload;
  logic              wd_react;

  assign wd_tick   = wd_tick_cnt_r == 32'(WD_TICK_CYC - 1);
  assign wd_reload = wr_ok && req_addr == ADDR_WD_RELOAD && req_wdata[WD_RELOAD_BIT];
  assign wd_react  = wr_ok && req_addr == ADDR_WD_RELOAD && req_wdata[WD_REACT_BIT];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wd_tick_cnt_r <= 32'h0;
    end else if (wd_reload || wd_react || wd_tick) begin
      wd_tick_cnt_r <= 32'h0;
    end else begin
      wd_tick_cnt_r <= wd_tick_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wd_active_r <= 1'b0;
      wd_cur_r    <= 16'h0;
      wd_load_r   <= 16'h0;
    end else if (wd_reload) begin
      // A new preset only takes effect here
      wd_load_r   <= wd_preset_r;
      wd_cur_r    <= wd_preset_r;
      wd_active_r <= wd_preset_r != 16'h0;
    end else if (wd_react && wd_active_r && wd_cur_r == 16'h0) begin
      wd_cur_r    <= wd_load_r;
    end else if (wd_active_r && wd_tick && wd_cur_r != 16'h0) begin
      wd_cur_r    <= wd_cur_r - 16'h1;
    end
  end

  // Exchange permission
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      exch_enable_r <= 1'b0;
    end else begin
      exch_enable_r <= (!wd_active_r || wd_cur_r != 16'h0)
                       && (ref_check_r != 16'h0001 || ref_list_match);
    end
  end

  // Force-mode lock: two consecutive code words
  logic [15:0]       lock_prev_r;
  logic              lock_wr;

  assign lock_wr = wr_ok && (req_addr == ADDR_FORCE_LOCK || req_addr == ADDR_FORCE_LOCK_HI);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_prev_r    <= 16'h0;
      force_locked_r <= 1'b0;
    end else if (lock_wr) begin
      lock_prev_r <= req_wdata;
      if (lock_prev_r == LOCK_WORD0 && req_wdata == LOCK_WORD1) begin
        force_locked_r <= 1'b1;
      end else if (lock_prev_r == FREE_WORD0 && req_wdata == FREE_WORD1) begin
        force_locked_r <= 1'b0;
      end
    end else if (wr_ok) begin
      // Any other accepted write breaks a half-entered code
      lock_prev_r <= 16'h0;
    end
  end

  // Connection idle timing
  logic [31:0]       sec_cnt_r;
  logic              sec_tick;
  logic [15:0]       idle_r [NCONN];
  logic [NCONN-1:0]  conn_up_r;
  logic [NCONN-1:0]  drop_now;

  assign sec_tick = sec_cnt_r == 32'(SEC_CYC - 1);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sec_cnt_r <= 32'h0;
    end else begin
      sec_cnt_r <= sec_tick ? 32'h0 : sec_cnt_r + 32'h1;
    end
  end

  always_comb begin
    for (int c = 0; c < NCONN; c++) begin
      drop_now[c] = conn_up_r[c] && idle_timeout_r != 16'h0
                    && idle_r[c] >= idle_timeout_r;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      conn_up_r   <= '0;
      conn_drop_r <= '0;
      for (int c = 0; c < NCONN; c++) begin
        idle_r[c] <= 16'h0;
      end
    end else begin
      conn_drop_r <= drop_now;
      for (int c = 0; c < NCONN; c++) begin
        if (conn_open && conn_open_id == c[CW-1:0]) begin
          conn_up_r[c] <= 1'b1;
          idle_r[c]    <= 16'h0;
        end else if (drop_now[c] || (conn_close && conn_close_id == c[CW-1:0])) begin
          conn_up_r[c] <= 1'b0;
          idle_r[c]    <= 16'h0;
        end else if (req_valid && req_conn == c[CW-1:0]) begin
          idle_r[c]    <= 16'h0;
        end else if (sec_tick && conn_up_r[c] && idle_r[c] != 16'hffff) begin
          idle_r[c]    <= idle_r[c] + 16'h1;
        end
      end
    end
  end

  // Write authorization holder in single-writer mode
  logic              owner_gone;
  assign owner_gone = owner_v_r && ((conn_close && conn_close_id == owner_r)
                                    || drop_now[owner_r]);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      owner_v_r <= 1'b0;
      owner_r   <= '0;
    end else if (!single_writer_mode) begin
      owner_v_r <= 1'b0;
    end else if (owner_gone) begin
      owner_v_r <= 1'b0;
    end else if (!owner_v_r && wr) begin
      owner_v_r <= 1'b1;
      owner_r   <= req_conn;
    end else if (!owner_v_r && conn_open && early_write_grant) begin
      owner_v_r <= 1'b1;
      owner_r   <= conn_open_id;
    end
  end

  // Read data and answer
  logic [15:0]       rdata_nxt;
  logic [7:0]        exc_nxt;
  logic [15:0]       a;

  always_comb begin
    a         = req_addr;
    rdata_nxt = 16'h0;
    exc_nxt   = EXC_NONE;
    if (req_write) begin
      if (!wr_known) begin
        exc_nxt = EXC_BAD_ADDR;
      end else if (!write_allowed) begin
        exc_nxt = EXC_NO_AUTH;
      end
    end else if (a == ADDR_OUT_IMG_LEN) begin
      rdata_nxt = out_img_bits;
    end else if (a == ADDR_IN_IMG_LEN) begin
      rdata_nxt = in_img_bits;
    end else if (a == ADDR_MAP_REV) begin
      rdata_nxt = MAP_REV_ID;
    end else if (a[15:2] == ADDR_DIAG_FLAGS[15:2]) begin
      rdata_nxt = diag_flags_r[a[1:0]*16 +: 16];
    end else if (a[15:2] == ADDR_ALARM_FLAGS[15:2]) begin
      rdata_nxt = alarm_flags_r[a[1:0]*16 +: 16];
    end else if (a[15:3] == ADDR_MOD_STATUS[15:3]) begin
      rdata_nxt = mod_status_r[a[2:0]*16 +: 16];
    end else if (a == ADDR_WD_REMAIN) begin
      rdata_nxt = wd_active_r ? wd_cur_r : WD_OFF_VALUE;
    end else if (a == ADDR_CONN_MODE) begin
      rdata_nxt = conn_mode_r;
    end else if (a == ADDR_WD_PRESET) begin
      rdata_nxt = wd_preset_r;
    end else if (a == ADDR_IDLE_TIMEOUT) begin
      rdata_nxt = idle_timeout_r;
    end else if (a == ADDR_REF_CHECK) begin
      rdata_nxt = ref_check_r;
    end else if (a == ADDR_ALARM_MODE) begin
      rdata_nxt = alarm_mode_r;
    end else if (a == ADDR_DIAG_MODE) begin
      rdata_nxt = diag_mode_r;
    end else if (a == ADDR_WD_RELOAD || a == ADDR_FORCE_LOCK
                 || a == ADDR_FORCE_LOCK_HI || rd_diag_mem || rd_alarm_mem) begin
      // Write-only codes and the message memories (held elsewhere) read as zero
      rdata_nxt = 16'h0;
    end else begin
      exc_nxt = EXC_BAD_ADDR;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      resp_valid_r <= 1'b0;
      resp_rdata_r <= 16'h0;
      resp_exc_r   <= EXC_NONE;
    end else begin
      resp_valid_r <= req_valid;
      resp_rdata_r <= req_valid ? rdata_nxt : 16'h0;
      resp_exc_r   <= req_valid ? exc_nxt : EXC_NONE;
    end
  end

endmodule

// file: verilog/mbacs_pkg.sv
package mbacs_pkg;

  // Register word addresses (16-bit registers)
  localparam logic [15:0] ADDR_OUT_IMG_LEN   = 16'h1010;
  localparam logic [15:0] ADDR_IN_IMG_LEN    = 16'h1011;
  localparam logic [15:0] ADDR_MAP_REV       = 16'h1017;
  localparam logic [15:0] ADDR_DIAG_FLAGS    = 16'h1018;
  localparam logic [15:0] ADDR_ALARM_FLAGS   = 16'h101c;
  localparam logic [15:0] ADDR_MOD_STATUS    = 16'h1028;
  localparam logic [15:0] ADDR_WD_REMAIN     = 16'h1030;
  localparam logic [15:0] ADDR_CONN_MODE     = 16'h1031;
  localparam logic [15:0] ADDR_WD_PRESET     = 16'h1120;
  localparam logic [15:0] ADDR_WD_RELOAD     = 16'h1121;
  localparam logic [15:0] ADDR_FORCE_LOCK    = 16'h1122;
  localparam logic [15:0] ADDR_FORCE_LOCK_HI = 16'h1123;
  localparam logic [15:0] ADDR_IDLE_TIMEOUT  = 16'h1131;
  localparam logic [15:0] ADDR_REF_CHECK     = 16'h1132;
  localparam logic [15:0] ADDR_ALARM_MODE    = 16'h1133;
  localparam logic [15:0] ADDR_DIAG_MODE     = 16'h1134;
  localparam logic [3:0]  AREA_DIAG_MEM      = 4'ha;
  localparam logic [3:0]  AREA_ALARM_MEM     = 4'hb;
  localparam logic [3:0]  AREA_LEN_HI        = 4'h0;

  // Field positions
  localparam int WD_RELOAD_BIT      = 0;
  localparam int WD_REACT_BIT       = 8;
  localparam int MODE_SINGLE_BIT    = 0;
  localparam int MODE_EARLY_BIT     = 1;
  localparam int SLOT_LSB           = 5;

  // Reset values and fixed codes
  localparam logic [15:0] WD_OFF_VALUE      = 16'hffff;
  localparam logic [15:0] CFG_RESET         = 16'h0000;
  localparam logic [15:0] LOCK_WORD0        = 16'h4c4f;
  localparam logic [15:0] LOCK_WORD1        = 16'h434b;
  localparam logic [15:0] FREE_WORD0        = 16'h4652;
  localparam logic [15:0] FREE_WORD1        = 16'h4545;
  localparam logic [7:0]  EXC_NONE          = 8'h00;
  localparam logic [7:0]  EXC_NO_AUTH       = 8'h01;
  localparam logic [7:0]  EXC_BAD_ADDR      = 8'h02;

  // Timing
  localparam int CLK_HZ        = 200_000_000;
  localparam int WD_UNIT_MS    = 10;
  localparam int WD_UNIT_CYC   = CLK_HZ / 1000 * WD_UNIT_MS;
  localparam int IDLE_UNIT_S   = 1;
  localparam int IDLE_UNIT_CYC = CLK_HZ * IDLE_UNIT_S;

endpackage

// file: verification/mbacs_regs_asserts.sv
`timescale 1ns/100ps
module mbacs_regs_chk
  import mbacs_pkg::*;
(
  // Clock and reset
  input wire logic         clk,
  input wire logic         sys_rst,
  // Register request and answer
  input wire logic         req_valid,
  input wire logic         req_write,
  input wire logic [15:0]  req_addr,
  input wire logic [15:0]  req_wdata,
  input wire logic         resp_valid_r,
  input wire logic [15:0]  resp_rdata_r,
  input wire logic [7:0]   resp_exc_r,
  // Events and state
  input wire logic         diag_evt,
  input wire logic         alarm_evt,
  input wire logic [127:0] mod_status,
  input wire logic         force_locked_r,
  input wire logic [63:0]  diag_flags_r,
  input wire logic [63:0]  alarm_flags_r
);
  logic wr_req;
  logic lock_wr;
  logic free_wr;
  assign wr_req  = req_valid && req_write;
  assign lock_wr = wr_req && req_wdata == LOCK_WORD1;
  assign free_wr = wr_req && req_wdata == FREE_WORD1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_resp_follows: assert property (req_valid |=> resp_valid_r)
    else $error("no answer one cycle after a request");
  chk_resp_cause: assert property (resp_valid_r |-> $past(req_valid))
    else $error("answer without a request");
  chk_idle_data: assert property (!resp_valid_r |-> resp_rdata_r == 16'h0000)
    else $error("read data not zero outside an answer");
  chk_status_word: assert property (req_valid && !req_write && req_addr == ADDR_MOD_STATUS
    && $stable(mod_status) |=> resp_rdata_r == $past(mod_status[15:0]))
    else $error("status word differs from module status");
  chk_diag_rise: assert property ($rose(|diag_flags_r) |-> $past(diag_evt, 2))
    else $error("diagnostic flag rose without an event");
  chk_alarm_rise: assert property ($rose(|alarm_flags_r) |-> $past(alarm_evt, 2))
    else $error("alarm flag rose without an event");
  chk_diag_fall: assert property ($fell(|diag_flags_r) |-> $past(req_valid, 2))
    else $error("diagnostic flag fell without a read");
  chk_alarm_fall: assert property ($fell(|alarm_flags_r) |-> $past(req_valid, 2))
    else $error("alarm flag fell without a read");
  chk_lock_rise: assert property ($rose(force_locked_r) |-> $past(lock_wr))
    else $error("force lock set without the second lock word");
  chk_free_fall: assert property ($fell(force_locked_r) |-> $past(free_wr))
    else $error("force lock cleared without the second free word");
  chk_noauth_cause: assert property (resp_exc_r == EXC_NO_AUTH |-> $past(wr_req))
    else $error("refusal code on something other than a write");
  cov_diag: cover property ($rose(|diag_flags_r));
  cov_lock: cover property ($rose(force_locked_r));
  cov_noauth: cover property (resp_exc_r == EXC_NO_AUTH);
endmodule
bind mbacs_regs mbacs_regs_chk u_chk (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
  .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
  .resp_valid_r(resp_valid_r), .resp_rdata_r(resp_rdata_r), .resp_exc_r(resp_exc_r),
  .diag_evt(diag_evt), .alarm_evt(alarm_evt), .mod_status(mod_status),
  .force_locked_r(force_locked_r), .diag_flags_r(diag_flags_r), .alarm_flags_r(alarm_flags_r));

// file: verification/mbacs_master.sv
`timescale 1ns/100ps
module mbacs_master
  import mbacs_pkg::*;
(
  // Clock
  input wire logic        clk,
  // Request
  output logic            req_valid,
  output logic            req_write,
  output logic [1:0]      req_conn,
  output logic [15:0]     req_addr,
  output logic [15:0]     req_wdata,
  // Answer
  input wire logic        resp_valid_r,
  input wire logic [15:0] resp_rdata_r,
  input wire logic [7:0]  resp_exc_r
);
  initial begin
    {req_valid, req_write, req_conn, req_addr, req_wdata} = '0;
  end
  // Answer is taken one edge after the request; 0xff flags a missing answer
  task automatic xfer(input logic w, input logic [1:0] c, input logic [15:0] a, d,
                      output logic [15:0] q, output logic [7:0] e);
    @(posedge clk);
    #1 {req_valid, req_write, req_conn, req_addr, req_wdata} = {1'b1, w, c, a, d};
    @(posedge clk);
    #1;
    q = resp_rdata_r;
    e = resp_valid_r === 1'b1 ? resp_exc_r : 8'hff;
    // Released fields carry junk so nothing can lean on stale values
    {req_valid, req_addr, req_wdata} = {1'b0, ~a, ~d};
  endtask
endmodule

// file: verification/tb_top.sv
`timescale 1ns/100ps
module tb_top
  import mbacs_pkg::*;
;
  localparam int TICK = 4;
  localparam int SEC  = 8;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid, req_write, resp_valid_r, conn_open, conn_close;
  logic diag_evt, alarm_evt, ref_list_match, exch_enable_r, force_locked_r;
  logic [1:0] req_conn, conn_open_id, conn_close_id;
  logic [15:0] req_addr, req_wdata, resp_rdata_r, out_img_bits, in_img_bits, v;
  logic [7:0] resp_exc_r, e;
  logic [3:0] conn_drop_r;
  logic [5:0] diag_slot, alarm_slot, s;
  logic [127:0] mod_status;
  logic [63:0] diag_flags_r, alarm_flags_r;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int pend[2][$];
  always #2.5 clk = ~clk;
  mbacs_master M (.*);
  mbacs_regs #(.WD_TICK_CYC(TICK), .SEC_CYC(SEC)) DUT (.*);
  task automatic print_verdict;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic cmp(string nm, logic [15:0] x, logic [15:0] g);
    compares++;
    if (g !== x) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic wr(logic [1:0] c, logic [15:0] a, d, logic [7:0] x);
    M.xfer(1'b1, c, a, d, v, e);
    cmp("write code", {8'h00, x}, {8'h00, e});
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] x);
    M.xfer(1'b0, 2'h0, a, 16'h0000, v, e);
    cmp("read code", {8'h00, x}, {8'h00, e});
  endtask
  task automatic pulse(int k, logic [5:0] sl);
    @(posedge clk);
    #1 {diag_slot, alarm_slot, conn_open_id, conn_close_id} = {sl, sl, sl[1:0], sl[1:0]};
    {diag_evt, alarm_evt, conn_open, conn_close} = 4'b0001 << (3 - k);
    @(posedge clk);
    #1 {diag_evt, alarm_evt, conn_open, conn_close} = 4'b0000;
    if (k < 2) pend[k].push_back(sl);
  endtask
  initial begin
    {conn_open, conn_close, diag_evt, alarm_evt, conn_open_id, conn_close_id} = '0;
    {diag_slot, alarm_slot, mod_status, ref_list_match} = '0;
    v = $urandom(81370);
    out_img_bits = $urandom;
    in_img_bits = $urandom;
    repeat (12) @(posedge clk);
    #1 sys_rst = 1'b0;
    mod_status = {$urandom, $urandom, $urandom, $urandom};
    @(posedge clk);
    #1 cmp("exch", 16'h0001, {15'h0, exch_enable_r});
    rd(ADDR_WD_REMAIN, EXC_NONE);
    cmp("remain", WD_OFF_VALUE, v);
    rd(ADDR_OUT_IMG_LEN, EXC_NONE);
    cmp("out len", out_img_bits, v);
    rd(ADDR_IN_IMG_LEN, EXC_NONE);
    cmp("in len", in_img_bits, v);
    for (int i = 0; i < 8; i++) begin
      rd(ADDR_MOD_STATUS + 16'(i), EXC_NONE);
      cmp("status", mod_status[i*16 +: 16], v);
    end
    rd(16'h1040, EXC_BAD_ADDR);
    wr(0, ADDR_WD_REMAIN, 16'h1234, EXC_BAD_ADDR);
    for (int k = 0; k < 2; k++) begin
      wr(0, k ? ADDR_ALARM_MODE : ADDR_DIAG_MODE, 16'h0001, EXC_NONE);
      s = 6'($urandom);
      pulse(k, s);
      pulse(k, s);
      for (int r = 0; r < 3; r++) begin
        rd((k ? ADDR_ALARM_FLAGS : ADDR_DIAG_FLAGS) + 16'(s[5:4]), EXC_NONE);
        cmp("flags", 16'(pend[k].size() > 0) << s[3:0], v);
        cmp("flag out", 16'(pend[k].size() > 0), 16'((k ? alarm_flags_r : diag_flags_r) >> s));
        if (r < 2) rd({k ? AREA_ALARM_MEM : AREA_DIAG_MEM, 1'b0, s, 5'h00}, EXC_NONE);
        if (r < 2) void'(pend[k].pop_front());
      end
    end
    wr(0, ADDR_WD_PRESET, 16'h0003, EXC_NONE);
    rd(ADDR_WD_REMAIN, EXC_NONE);
    cmp("preset only", WD_OFF_VALUE, v);
    for (int r = 0; r < 2; r++) begin
      wr(0, ADDR_WD_RELOAD, r ? 16'h0100 : 16'h0001, EXC_NONE);
      rd(ADDR_WD_REMAIN, EXC_NONE);
      cmp("running", 16'h0001, 16'(v == 3 || v == 2));
      repeat (3 * TICK + 4) @(posedge clk);
      rd(ADDR_WD_REMAIN, EXC_NONE);
      cmp("expired", 16'h0000, v);
      cmp("exch off", 16'h0000, {15'h0, exch_enable_r});
    end
    wr(0, ADDR_WD_PRESET, 16'h0000, EXC_NONE);
    wr(0, ADDR_WD_RELOAD, 16'h0001, EXC_NONE);
    rd(ADDR_WD_REMAIN, EXC_NONE);
    cmp("wd off", WD_OFF_VALUE, v);
    wr(0, ADDR_FORCE_LOCK, LOCK_WORD0, EXC_NONE);
    wr(0, ADDR_IDLE_TIMEOUT, 16'h0000, EXC_NONE);
    wr(0, ADDR_FORCE_LOCK, LOCK_WORD1, EXC_NONE);
    cmp("split lock", 16'h0000, {15'h0, force_locked_r});
    wr(0, ADDR_FORCE_LOCK, LOCK_WORD0, EXC_NONE);
    wr(0, ADDR_FORCE_LOCK, LOCK_WORD1, EXC_NONE);
    @(posedge clk);
    #1 cmp("locked", 16'h0001, {15'h0, force_locked_r});
    wr(0, ADDR_FORCE_LOCK, FREE_WORD0, EXC_NONE);
    wr(0, ADDR_FORCE_LOCK, FREE_WORD1, EXC_NONE);
    @(posedge clk);
    #1 cmp("freed", 16'h0000, {15'h0, force_locked_r});
    wr(0, ADDR_CONN_MODE, 16'h0001, EXC_NONE);
    pulse(3, 0);
    wr(2, ADDR_WD_PRESET, 16'h0000, EXC_NONE);
    wr(3, ADDR_WD_PRESET, 16'h0000, EXC_NO_AUTH);
    pulse(3, 2);
    wr(3, ADDR_CONN_MODE, 16'h0003, EXC_NONE);
    pulse(2, 1);
    wr(1, ADDR_WD_PRESET, 16'h0000, EXC_NO_AUTH);
    pulse(3, 3);
    pulse(2, 0);
    wr(1, ADDR_WD_PRESET, 16'h0000, EXC_NO_AUTH);
    wr(0, ADDR_CONN_MODE, 16'h0000, EXC_NONE);
    wr(1, ADDR_IDLE_TIMEOUT, 16'h0002, EXC_NONE);
    s = 0;
    for (int i = 0; i < 3 * SEC + 8 && conn_drop_r[1] !== 1'b1; i++) begin
      @(posedge clk);
      #1 s = 6'(i);
    end
    cmp("idle drop", 16'h0001, 16'(conn_drop_r[1] === 1'b1 && s >= SEC));
    wr(0, ADDR_IDLE_TIMEOUT, 16'h0000, EXC_NONE);
    for (int r = 0; r < 3; r++) begin
      wr(0, ADDR_REF_CHECK, 16'(r < 2), EXC_NONE);
      ref_list_match = (r == 1);
      repeat (2) @(posedge clk);
      #1 cmp("exch ref", 16'(r > 0), {15'h0, exch_enable_r});
    end
    print_verdict();
  end
endmodule
